// ---- slsd_ctl_model.sv ----
// Controller model driving the serial, latch, wipe and enable pins
`timescale 1ns/1ps
module slsd_ctl_model (
  // Serial pins
  output logic shift_clock,
  output logic chain_input,
  // Latch, wipe and enable pins
  output logic latch_clock,
  output logic shift_wipe_n,
  output logic drive_en_n
);
  // ----------------
  // Pin drivers
  // ----------------
  // Clocks stand still outside frames, wipe inactive, drive off
  initial begin
    shift_clock  <= 1'b0;
    latch_clock  <= 1'b0;
    chain_input  <= 1'b0;
    shift_wipe_n <= 1'b1;
    drive_en_n   <= 1'b1;
  end
  // One bit per 64 ns period; line inverted after hold so no stale bit lingers
  task automatic shift_bit(input logic b);
    chain_input <= b;
    #32 shift_clock <= 1'b1;
    #24 chain_input <= ~b;
    #8 shift_clock <= 1'b0;
  endtask : shift_bit
  // First bit sent ends in the last stage
  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(v[i]);
    end
  endtask : shift_byte
  // Latch pulse after a whole pattern
  task automatic latch();
    latch_clock <= 1'b1;
    #64 latch_clock <= 1'b0;
  endtask : latch
  task automatic set_lvl(input logic wipe_n, input logic en_n);
    shift_wipe_n <= wipe_n;
    drive_en_n   <= en_n;
  endtask : set_lvl
endmodule : slsd_ctl_model

// ---- slsd_fifo.sv ----
// Small valid/ready FIFO carrying latched patterns toward the output stage
`timescale 1ns/1ps
module slsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // ---------------------------------------------------------------------------
  // Honest flags straight from the fill count
  // ---------------------------------------------------------------------------
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];

  // Pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop)  rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (ce && push) mem[wp_r] <= in_data;
  end

  a_fifo_no_overrun : assert property (@(posedge clk) disable iff (rst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : slsd_fifo

// ---- slsd_pkg.sv ----
// Package for the serial latched sink driver: widths, reset values, FIFO depth
package slsd_pkg;
  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          SLSD_WIDTH      = 8;
  localparam int          SLSD_FIFO_DEPTH = 8;
  localparam logic [7:0]  SLSD_SHIFT_RST  = 8'h00;
  localparam logic [7:0]  SLSD_STORE_RST  = 8'h00;
  localparam logic [2:0]  SLSD_SYNC_RST   = 3'h0;
  localparam logic [2:0]  SLSD_SYNC_SET   = 3'h7;
  localparam logic        SLSD_LVL_LO     = 1'h0;
  localparam logic        SLSD_LVL_HI     = 1'h1;
  localparam logic [7:0]  SLSD_SINK_RST   = 8'h00;
  localparam logic [7:0]  SLSD_OE_OFF     = 8'hFF;
  // Pin timing, kept for reference against the 5 ns clock
  localparam int          SLSD_CLK_PS     = 5000;
  localparam int          SLSD_SETUP_PS   = 20000;
  localparam int          SLSD_SETUP_CYC  = (SLSD_SETUP_PS + SLSD_CLK_PS - 1) / SLSD_CLK_PS;

  // Agreed level: a pin change counts only once stages 2 and 3 match
  function automatic logic slsd_hold(input logic [2:0] s, input logic lvl);
    slsd_hold = (s[1] == s[2]) ? s[2] : lvl;
  endfunction : slsd_hold

  // Rising edge of the agreed level, so a one-cycle glitch never counts
  function automatic logic slsd_rise(input logic [2:0] s, input logic lvl);
    slsd_rise = slsd_hold(s, lvl) & ~lvl;
  endfunction : slsd_rise
endpackage : slsd_pkg

// ---- slsd_top.sv ----
// Serial latched sink driver: shift register, storage register, gated sinks
`timescale 1ns/1ps
module slsd_top
  import slsd_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Controller pins, asynchronous to clk
  input  wire logic        shift_clock,
  input  wire logic        latch_clock,
  input  wire logic        chain_input,
  input  wire logic        shift_wipe_n,
  input  wire logic        drive_en_n,
  // Cascade pin toward the next device
  output logic             cascade_out,
  // Open-drain sink pins: output value and active-low enable
  output logic [7:0]       sink_o,
  output logic [7:0]       sink_oe_n,
  // Registered FIFO full flag: high while a new latch would be dropped
  output logic             fifo_stall
);
  // ---------------------------------------------------------------------------
  // Input synchronisers: three stages, change taken when stages 2 and 3 agree, except the data pin, which uses stage 3 alone
  // ---------------------------------------------------------------------------
  logic [2:0] sck_s_r;
  logic [2:0] lck_s_r;
  logic [2:0] din_s_r;
  logic [2:0] wip_s_r;
  logic [2:0] den_s_r;
  logic       sck_lvl_r;
  logic       lck_lvl_r;
  logic       wip_lvl_r;
  logic       den_lvl_r;

  // Stage 1 is read only by stage 2
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_s_r <= SLSD_SYNC_RST;
      lck_s_r <= SLSD_SYNC_RST;
      din_s_r <= SLSD_SYNC_RST;
      wip_s_r <= SLSD_SYNC_SET;
      den_s_r <= SLSD_SYNC_SET;
    end else if (ce) begin
      sck_s_r <= {sck_s_r[1:0], shift_clock};
      lck_s_r <= {lck_s_r[1:0], latch_clock};
      din_s_r <= {din_s_r[1:0], chain_input};
      wip_s_r <= {wip_s_r[1:0], shift_wipe_n};
      den_s_r <= {den_s_r[1:0], drive_en_n};
    end
  end

  // Agreed level of each pin except the data pin, which takes stage 3 directly, then edges and levels from it
  wire sck_lvl  = slsd_hold(sck_s_r, sck_lvl_r);
  wire lck_lvl  = slsd_hold(lck_s_r, lck_lvl_r);
  wire wip_lvl  = slsd_hold(wip_s_r, wip_lvl_r);
  wire den_lvl  = slsd_hold(den_s_r, den_lvl_r);
  wire sck_rise = slsd_rise(sck_s_r, sck_lvl_r);
  wire lck_rise = slsd_rise(lck_s_r, lck_lvl_r);
  wire din_lvl  = din_s_r[2];
  wire wipe_act = ~wip_lvl;
  wire drv_off  = den_lvl;

  // Held levels bridge cycles where stages 2 and 3 disagree, so a glitch
  // shorter than one clock never counts; wipe and enable start inactive
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_lvl_r <= SLSD_LVL_LO;
      lck_lvl_r <= SLSD_LVL_LO;
      wip_lvl_r <= SLSD_LVL_HI;
      den_lvl_r <= SLSD_LVL_HI;
    end else if (ce) begin
      sck_lvl_r <= sck_lvl;
      lck_lvl_r <= lck_lvl;
      wip_lvl_r <= wip_lvl;
      den_lvl_r <= den_lvl;
    end
  end

  // ---------------------------------------------------------------------------
  // Shift and storage registers
  // ---------------------------------------------------------------------------
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] store_r;
  logic       pat_valid;
  logic       pat_ready;
  logic [7:0] pat_data;
  logic       fifo_in_ready;

  // Data bit is the stage-3 sample taken with the clock edge's first sample;
  // the pin hold time after the edge covers that one-cycle skew
  assign shift_nxt = wipe_act ? SLSD_SHIFT_RST :
                     sck_rise ? {shift_r[6:0], din_lvl} :
                     shift_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= SLSD_SHIFT_RST;
    end else if (ce) begin
      shift_r <= shift_nxt;
    end
  end

  // Cascade pin follows the last stage after each shift edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cascade_out <= SLSD_LVL_LO;
    end else if (ce) begin
      cascade_out <= shift_nxt[7];
    end
  end

  // Latched patterns travel through a FIFO; a full FIFO drops the latch
  slsd_fifo #(
    .WIDTH (SLSD_WIDTH),
    .DEPTH (SLSD_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (lck_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_r),
    .out_valid (pat_valid),
    .out_ready (pat_ready),
    .out_data  (pat_data)
  );

  // Drain at once, so latency is one cycle and the FIFO stays near empty
  assign pat_ready = 1'b1;

  // Storage register is not touched by the wipe input
  always_ff @(posedge clk) begin
    if (rst) begin
      store_r <= SLSD_STORE_RST;
    end else if (ce && pat_valid) begin
      store_r <= pat_data;
    end
  end

  // ---------------------------------------------------------------------------
  // Output buffer and open-drain sinks
  // ---------------------------------------------------------------------------
  wire [7:0] buf_nxt = (drv_off || wipe_act) ? 8'h00 : store_r;

  // Registered pins: a one pulls low (enable low), a zero releases
  always_ff @(posedge clk) begin
    if (rst) begin
      sink_o     <= SLSD_SINK_RST;
      sink_oe_n  <= SLSD_OE_OFF;
      fifo_stall <= SLSD_LVL_LO;
    end else if (ce) begin
      sink_o     <= 8'h00;
      sink_oe_n  <= ~buf_nxt;
      fifo_stall <= ~fifo_in_ready;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_wipe_clears_shift : assert property (@(posedge clk) disable iff (rst || !ce)
    wipe_act |=> shift_r == 8'h00) else $error("shift not wiped");
  a_shift_moves_bit : assert property (@(posedge clk) disable iff (rst || !ce)
    (sck_rise && !wipe_act) |=> shift_r == {$past(shift_r[6:0]), $past(din_lvl)})
    else $error("shift step wrong");
  a_shift_holds : assert property (@(posedge clk) disable iff (rst || !ce)
    (!sck_rise && !wipe_act) |=> $stable(shift_r)) else $error("shift moved without edge");
  a_cascade_last : assert property (@(posedge clk) disable iff (rst || !ce)
    1'b1 |=> cascade_out == shift_r[7]) else $error("cascade not last stage");
  a_latch_copies : assert property (@(posedge clk) disable iff (rst || !ce)
    (lck_rise && fifo_in_ready) |=> ##1 store_r == $past(shift_r, 2))
    else $error("storage did not copy");
  a_wipe_keeps_store : assert property (@(posedge clk) disable iff (rst || !ce)
    (wipe_act && !pat_valid) |=> $stable(store_r)) else $error("wipe hit storage");
  a_drive_off_all : assert property (@(posedge clk) disable iff (rst || !ce)
    drv_off |=> sink_oe_n == 8'hFF) else $error("sinks on while disabled");
  a_drive_follows : assert property (@(posedge clk) disable iff (rst || !ce)
    (!drv_off && !wipe_act) |=> sink_oe_n == ~$past(store_r)) else $error("buffer not following");
  a_wipe_blocks_out : assert property (@(posedge clk) disable iff (rst || !ce)
    wipe_act |=> sink_oe_n == 8'hFF) else $error("storage passed during wipe");
  a_sink_low_only : assert property (@(posedge clk) disable iff (rst)
    sink_o == 8'h00) else $error("sink drives high");

  // Clock enable low must freeze everything the pins can move
  a_freeze_holds : assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(shift_r) && $stable(store_r) && $stable(sink_oe_n))
    else $error("state moved while frozen");
  // Cascade takes the stage just below the last one on each shift
  a_cascade_steps : assert property (@(posedge clk) disable iff (rst || !ce)
    (sck_rise && !wipe_act) |=> cascade_out == $past(shift_r[6]))
    else $error("cascade skipped a stage");
  // A pattern never waits: the FIFO is drained the cycle it shows valid
  a_fifo_drained : assert property (@(posedge clk) disable iff (rst || !ce)
    pat_valid |=> !pat_valid || $past(lck_rise))
    else $error("pattern left waiting");
  // Storage moves only when a pattern leaves the FIFO
  a_store_by_fifo : assert property (@(posedge clk) disable iff (rst || !ce)
    !pat_valid |=> $stable(store_r))
    else $error("storage moved without a pattern");

  c_shift_edge : cover property (@(posedge clk) disable iff (rst) sck_rise && din_lvl);
  c_latch_edge : cover property (@(posedge clk) disable iff (rst) lck_rise);
  c_sinks_on   : cover property (@(posedge clk) disable iff (rst) sink_oe_n != 8'hFF);
  c_wipe_seen  : cover property (@(posedge clk) disable iff (rst) wipe_act && shift_r != 8'h00);
  // Freeze released again, so the bench proves state survives it
  c_freeze_seen : cover property (@(posedge clk) disable iff (rst) !ce ##1 ce);
endmodule : slsd_top

// ---- slsd_top_tb.sv ----
// Self-checking bench for the serial latched sink driver
`timescale 1ns/1ps
module slsd_top_tb;
  import slsd_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce  = 1'b1;
  wire logic  shift_clock, latch_clock, chain_input, shift_wipe_n, drive_en_n;
  wire logic  cascade_out, fifo_stall;
  wire logic [7:0] sink_o, sink_oe_n;
  int         n_mismatch = 0;
  int         n_tests    = 0;
  initial forever #2.5 clk = ~clk;
  slsd_ctl_model ctl_u (.shift_clock(shift_clock), .chain_input(chain_input),
    .latch_clock(latch_clock), .shift_wipe_n(shift_wipe_n), .drive_en_n(drive_en_n));
  slsd_top dut_u (.clk(clk), .rst(rst), .ce(ce), .shift_clock(shift_clock),
    .latch_clock(latch_clock), .chain_input(chain_input), .shift_wipe_n(shift_wipe_n),
    .drive_en_n(drive_en_n), .cascade_out(cascade_out), .sink_o(sink_o),
    .sink_oe_n(sink_oe_n), .fifo_stall(fifo_stall));
  // ----------------
  // Compare and closing tasks
  // ----------------
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check8
  task automatic check1(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask : check1
  // Pin path is about six cycles; twelve leaves margin
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask : settle
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_pattern(input logic [7:0] p);
    ctl_u.shift_byte(p);
    ctl_u.latch();
    settle();
    check8("sink_oe_n", ~p, sink_oe_n);
    check8("sink_o", 8'h00, sink_o);
  endtask : t_pattern
  task automatic t_cascade();
    logic [7:0] pat;
    pat = 8'hC3;
    ctl_u.shift_byte(pat);
    settle();
    check1("cascade_out", 1'b1, cascade_out);
    for (int i = 6; i >= 0; i--) begin
      ctl_u.shift_bit(1'b0);
      settle();
      check1("cascade_out", pat[i], cascade_out);
    end
  endtask : t_cascade
  task automatic t_enable();
    ctl_u.set_lvl(1'b1, 1'b1);
    settle();
    check8("sink_oe_n", 8'hFF, sink_oe_n);
    ctl_u.set_lvl(1'b1, 1'b0);
    settle();
    check8("sink_oe_n", 8'h5A, sink_oe_n);
  endtask : t_enable
  // Clock enable low: pins move, yet no register may follow until it returns
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    ctl_u.shift_byte(8'h3C);
    ctl_u.latch();
    ctl_u.set_lvl(1'b0, 1'b1);
    settle();
    check8("sink_oe_n", 8'h5A, sink_oe_n);
    check1("cascade_out", 1'b1, cascade_out);
    ctl_u.set_lvl(1'b1, 1'b0);
    settle();
    @(posedge clk);
    ce <= 1'b1;
    settle();
    check8("sink_oe_n", 8'h5A, sink_oe_n);
    check1("cascade_out", 1'b1, cascade_out);
  endtask : t_freeze
  task automatic t_wipe();
    ctl_u.set_lvl(1'b0, 1'b0);
    settle();
    check8("sink_oe_n", 8'hFF, sink_oe_n);
    check1("cascade_out", 1'b0, cascade_out);
    ctl_u.set_lvl(1'b1, 1'b0);
    settle();
    check8("sink_oe_n", 8'h5A, sink_oe_n);
    ctl_u.latch();
    settle();
    check8("sink_oe_n", 8'hFF, sink_oe_n);
  endtask : t_wipe
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle();
    check1("cascade_out", 1'b0, cascade_out);
    check8("sink_oe_n", 8'hFF, sink_oe_n);
    ctl_u.set_lvl(1'b1, 1'b0);
    t_pattern(8'h01);
    t_pattern(8'h80);
    t_cascade();
    t_pattern(8'hA5);
    t_enable();
    t_freeze();
    t_wipe();
    check1("fifo_stall", 1'b0, fifo_stall);
    complete_run();
  end
  // Watchdog, well past the few microseconds the run needs
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule : slsd_top_tb
